// >>> hw/timer8_output_compare_normal.sv
// 8-bit timer counter with two output compare channels and pin override
`timescale 1ns/100ps

// Behaviour
// - compare counter with both compare values always; match when equal.
// - flag set on the timer tick after equality is seen.
// - set flag with enable requests interrupt; acknowledge clears the flag.
// - writing one to a flag bit clears it; zero leaves it.
// - PWM modes buffer compare writes, loaded at top or bottom.
// - buffered writes reach buffer; unbuffered reach the active value.
// - force strobe in non-PWM modes acts on output only.
// - counter write blocks matches in the next timer tick, even stopped.
// - output state survives mode change; reset clears it to zero.
// - output mode unbuffered; applies at first match after write.
// - nonzero output mode overrides port data; direction from port.
// - output state reaches pin only when direction is output.
// - output mode zero leaves output state alone on match.
// - waveform mode sets counting; output mode sets pin action.
// - normal mode increments on every running tick, wraps max to zero.
// - overflow flag set as normal counting wraps max to zero; counting never clears it.
// - overflow interrupt acknowledge clears overflow flag.
// - normal mode accepts counter writes at any time.
// - counter write beats clear or count in the same cycle.
// - mode two clears counter on channel A match.
// - modes three and seven are fast PWM, buffered.
// - modes one and five are phase correct PWM, buffered.
module timer8_output_compare_normal
  import timer8_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // timer tick enable from the prescaler
  input  wire logic         tick_i,
  // register port
  input  wire logic [3:0]   addr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [W-1:0] rdata_o,
  // interrupt requests and acknowledges
  output logic              irq_ovf_o,
  output logic              irq_cmp_a_o,
  output logic              irq_cmp_b_o,
  input  wire logic         ack_ovf_i,
  input  wire logic         ack_cmp_a_i,
  input  wire logic         ack_cmp_b_i,
  // port pins
  input  wire logic [1:0]   port_data_i,
  input  wire logic [1:0]   compare_pin_direction_i,
  output logic      [1:0]   pin_o,
  output logic      [1:0]   pin_oe_o
);

  logic [W-1:0] timer_count;
  logic [W-1:0] compare_value_a;
  logic [W-1:0] compare_value_b;
  logic [W-1:0] buf_a;
  logic [W-1:0] buf_b;
  logic [7:0]   ctrl;
  logic [2:0]   irq_en;
  logic         overflow_flag;
  logic         compare_flag_a;
  logic         compare_flag_b;
  logic [1:0]   compare_output_state;
  logic         count_down;
  logic         block_pend;
  logic [1:0]   match_q;

  wgm_e        waveform_mode_select;
  logic        running;
  logic [1:0]  com_a;
  logic [1:0]  com_b;
  assign waveform_mode_select = wgm_e'(ctrl[CTRL_WGM_LSB +: 3]);
  assign running = ctrl[CTRL_RUN_BIT];
  assign com_a   = ctrl[CTRL_COMA_LSB +: 2];
  assign com_b   = ctrl[CTRL_COMB_LSB +: 2];

  // mode decode
  wire is_fast = (waveform_mode_select == WGM_FAST_MAX)
               || (waveform_mode_select == WGM_FAST_OCR);
  wire is_pc   = (waveform_mode_select == WGM_PC_MAX)
               || (waveform_mode_select == WGM_PC_OCR);
  wire is_pwm  = is_fast || is_pc;
  wire is_ctc  = (waveform_mode_select == WGM_CTC);
  wire top_ocr = waveform_mode_select[2];
  wire [W-1:0] top_val = top_ocr ? compare_value_a : CNT_MAX;

  // register decode
  wire wr_count = wr_i && (addr_i == OFS_COUNT);
  wire wr_cmpa  = wr_i && (addr_i == OFS_CMP_A);
  wire wr_cmpb  = wr_i && (addr_i == OFS_CMP_B);
  wire wr_ctrl  = wr_i && (addr_i == OFS_CTRL);
  wire wr_flags = wr_i && (addr_i == OFS_FLAGS);
  wire wr_irqen = wr_i && (addr_i == OFS_IRQ_EN);
  wire wr_force = wr_i && (addr_i == OFS_FORCE);

  // comparator, gated by the block after a counter write
  wire [1:0] match_raw = {timer_count == compare_value_b,
                          timer_count == compare_value_a};
  wire       blocked   = block_pend || wr_count;
  wire [1:0] match     = (tick_i && running && !blocked) ? match_raw : 2'b00;

  // counter next value
  wire at_top    = (timer_count == top_val);
  wire at_bottom = (timer_count == CNT_BOTTOM);
  logic [W-1:0] next_count;
  logic         next_down;
  always_comb begin
    next_count = timer_count + W'(1);
    next_down  = count_down;
    if (is_ctc && match_raw[0]) begin
      next_count = CNT_BOTTOM;
    end else if (is_fast && at_top) begin
      next_count = CNT_BOTTOM;
    end else if (is_pc) begin
      if (at_top && !count_down) begin
        next_down  = 1'b1;
        next_count = timer_count - W'(1);
      end else if (at_bottom && count_down) begin
        next_down  = 1'b0;
      end else if (count_down) begin
        next_count = timer_count - W'(1);
      end
    end
  end
  wire step = tick_i && running;
  wire ovf_evt = step && (is_pc ? (at_bottom && count_down && timer_count != top_val)
                                : (next_count == CNT_BOTTOM && !is_ctc) ||
                                  (is_ctc && timer_count == CNT_MAX));
  wire load_buf = step && (is_fast ? (next_count == CNT_BOTTOM)
                                   : (is_pc && at_top && !count_down));

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_count <= RST_BYTE;
      count_down  <= 1'b0;
    end else if (wr_count) begin
      timer_count <= wdata_i;
    end else if (step) begin
      timer_count <= next_count;
      count_down  <= next_down;
    end
  end

  // block stays armed until the next timer tick passes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      block_pend <= 1'b0;
    end else if (wr_count) begin
      block_pend <= 1'b1;
    end else if (tick_i) begin
      block_pend <= 1'b0;
    end
  end

  // compare values and their buffers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_value_a <= RST_BYTE;
      compare_value_b <= RST_BYTE;
      buf_a           <= RST_BYTE;
      buf_b           <= RST_BYTE;
    end else begin
      if (wr_cmpa) begin
        buf_a <= wdata_i;
      end
      if (wr_cmpb) begin
        buf_b <= wdata_i;
      end
      if (!is_pwm && wr_cmpa) begin
        compare_value_a <= wdata_i;
      end else if (is_pwm && load_buf) begin
        compare_value_a <= buf_a;
      end
      if (!is_pwm && wr_cmpb) begin
        compare_value_b <= wdata_i;
      end else if (is_pwm && load_buf) begin
        compare_value_b <= buf_b;
      end
    end
  end

  // control and enables
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl   <= RST_BYTE;
      irq_en <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wdata_i;
      end
      if (wr_irqen) begin
        irq_en <= wdata_i[2:0];
      end
    end
  end

  // match delayed one timer tick to set the flags
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      match_q <= 2'b00;
    end else if (tick_i) begin
      match_q <= match;
    end
  end
  wire [1:0] flag_set = tick_i ? match_q : 2'b00;

  // flags: a set in the same cycle as a clear wins
  wire clr_ovf = ack_ovf_i   || (wr_flags && wdata_i[FLAG_OVF]);
  wire clr_a   = ack_cmp_a_i || (wr_flags && wdata_i[FLAG_CMA]);
  wire clr_b   = ack_cmp_b_i || (wr_flags && wdata_i[FLAG_CMB]);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_flag  <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
    end else begin
      overflow_flag  <= ovf_evt     || (overflow_flag  && !clr_ovf);
      compare_flag_a <= flag_set[0] || (compare_flag_a && !clr_a);
      compare_flag_b <= flag_set[1] || (compare_flag_b && !clr_b);
    end
  end

  assign irq_ovf_o   = overflow_flag  && irq_en[FLAG_OVF];
  assign irq_cmp_a_o = compare_flag_a && irq_en[FLAG_CMA];
  assign irq_cmp_b_o = compare_flag_b && irq_en[FLAG_CMB];

  // waveform generator per channel
  wire [1:0] force_hit = (wr_force && !is_pwm) ? wdata_i[1:0] : 2'b00;
  wire [3:0] com_all   = {com_b, com_a};
  wire       pwm_bot   = step && is_fast && (next_count == CNT_BOTTOM);
  wire  [1:0] next_state;
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      wire [1:0] com = com_all[2*ch +: 2];
      wire       hit = match[ch] || force_hit[ch];
      // one variable per channel keeps each bit to a single driver
      logic      nxt;
      always_comb begin
        nxt = compare_output_state[ch];
        if (!is_pwm && hit) begin
          unique case (com)
            2'b00: nxt = compare_output_state[ch];
            2'b01: nxt = !compare_output_state[ch];
            2'b10: nxt = 1'b0;
            2'b11: nxt = 1'b1;
          endcase
        end else if (is_fast && com[1]) begin
          if (match[ch]) begin
            nxt = com[0];
          end else if (pwm_bot) begin
            nxt = !com[0];
          end
        end else if (is_pc && com[1] && match[ch]) begin
          nxt = count_down ? !com[0] : com[0];
        end else if (is_pwm && com == 2'b01 && ch == 0 && top_ocr && match[ch]) begin
          nxt = !compare_output_state[ch];
        end
      end
      assign next_state[ch] = nxt;
      // port override: direction always from the port
      assign pin_o[ch]    = (com != 2'b00) ? compare_output_state[ch]
                                           : port_data_i[ch];
      assign pin_oe_o[ch] = compare_pin_direction_i[ch];
    end
  endgenerate

  // output state is untouched by mode writes
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compare_output_state <= 2'b00;
    end else begin
      compare_output_state <= next_state;
    end
  end

  // read mux
  logic [W-1:0] rd_mux;
  always_comb begin
    unique case (addr_i)
      OFS_COUNT:     rd_mux = timer_count;
      OFS_CMP_A:     rd_mux = is_pwm ? buf_a : compare_value_a;
      OFS_CMP_B:     rd_mux = is_pwm ? buf_b : compare_value_b;
      OFS_CTRL:      rd_mux = ctrl;
      OFS_FLAGS:     rd_mux = {5'h00, compare_flag_b, compare_flag_a, overflow_flag};
      OFS_IRQ_EN:    rd_mux = {5'h00, irq_en};
      OFS_OUT_STATE: rd_mux = {6'h00, compare_output_state};
      default:       rd_mux = RST_BYTE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= RST_BYTE;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= RST_BYTE;
    end
  end

  // checks
  chk_flag_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tick_i && match_q[0]) |=> compare_flag_a)
    else $error("flag a not set one tick after match");
  chk_flag_not_early: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (match[0] && !match_q[0] && !compare_flag_a) |=> !compare_flag_a)
    else $error("flag a set in the match tick");
  chk_block_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ((wr_count || block_pend) && !is_pwm && !wr_force) |=> $stable(compare_output_state))
    else $error("match acted while counter write block armed");
  chk_write_wins: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_count |=> timer_count == $past(wdata_i))
    else $error("counter write lost");
  chk_wrap_normal: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (step && !wr_count && waveform_mode_select == WGM_NORMAL && timer_count == CNT_MAX)
      |=> timer_count == CNT_BOTTOM && overflow_flag)
    else $error("normal wrap or overflow flag wrong");
  chk_normal_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (step && !wr_count && waveform_mode_select == WGM_NORMAL)
      |=> (timer_count == $past(timer_count) + W'(1)))
    else $error("normal mode did not increment");
  chk_ctc_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (step && !wr_count && is_ctc && match_raw[0]) |=> timer_count == CNT_BOTTOM)
    else $error("clear on match did not clear counter");
  chk_force_noflag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (force_hit[0] && !match[0] && !match_q[0] && !compare_flag_a) |=> !compare_flag_a)
    else $error("force set the flag");
  chk_force_pwm_ignored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_force && is_pwm && !tick_i) |=> $stable(compare_output_state))
    else $error("force acted in a pwm mode");
  chk_com_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (!is_pwm && com_a == 2'b00) |=> $stable(compare_output_state[0]))
    else $error("state changed with output mode zero");
  chk_mode_keeps_state: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_ctrl && !tick_i) |=> $stable(compare_output_state))
    else $error("mode write changed output state");
  chk_w1c_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_flags && wdata_i[FLAG_CMA] && !flag_set[0]) |=> !compare_flag_a)
    else $error("write one did not clear flag");
  chk_ack_clears_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ack_cmp_a_i && !flag_set[0]) |=> !compare_flag_a)
    else $error("acknowledge did not clear flag a");
  chk_ovf_ack: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ack_ovf_i && !ovf_evt) |=> !overflow_flag)
    else $error("acknowledge did not clear overflow flag");
  chk_ovf_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (overflow_flag && !clr_ovf) |=> overflow_flag)
    else $error("overflow flag cleared by counting");
  chk_pin_override: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (com_a != 2'b00) |-> pin_o[0] == compare_output_state[0])
    else $error("pin not overridden");
  chk_port_passthru: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (com_b == 2'b00) |-> pin_o[1] == port_data_i[1])
    else $error("port data not passed with output mode zero");
  chk_pin_direction: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    pin_oe_o == compare_pin_direction_i)
    else $error("pin enable not taken from direction bits");
  chk_direct_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_cmpa && !is_pwm) |=> compare_value_a == $past(wdata_i))
    else $error("unbuffered write missed active value");
  chk_buffered_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (wr_cmpa && is_pwm && !load_buf) |=> $stable(compare_value_a))
    else $error("pwm write reached active value");
  cov_ovf: cover property (@(posedge clk_i) ovf_evt);
  cov_match_flag: cover property (@(posedge clk_i) flag_set[0]);
  cov_force: cover property (@(posedge clk_i) force_hit != 2'b00);
  cov_load: cover property (@(posedge clk_i) load_buf);

endmodule : timer8_output_compare_normal

// >>> hw/timer8_pkg.sv
// constants shared by the 8-bit timer output compare block
package timer8_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_COUNT     = 4'h0;
  localparam logic [3:0] OFS_CMP_A     = 4'h1;
  localparam logic [3:0] OFS_CMP_B     = 4'h2;
  localparam logic [3:0] OFS_CTRL      = 4'h3;
  localparam logic [3:0] OFS_FLAGS     = 4'h4;
  localparam logic [3:0] OFS_IRQ_EN    = 4'h5;
  localparam logic [3:0] OFS_FORCE     = 4'h6;
  localparam logic [3:0] OFS_OUT_STATE = 4'h7;
  // control register fields
  localparam int CTRL_WGM_LSB  = 0;
  localparam int CTRL_RUN_BIT  = 3;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  // flag and enable bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMA = 1;
  localparam int FLAG_CMB = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_WGM  = 3'h0;
  // count limits
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // waveform modes
  typedef enum logic [2:0] {
    WGM_NORMAL   = 3'b000,
    WGM_PC_MAX   = 3'b001,
    WGM_CTC      = 3'b010,
    WGM_FAST_MAX = 3'b011,
    WGM_RSV4     = 3'b100,
    WGM_PC_OCR   = 3'b101,
    WGM_RSV6     = 3'b110,
    WGM_FAST_OCR = 3'b111
  } wgm_e;
endpackage : timer8_pkg

// >>> sim/test_timer8_output_compare_normal.sv
// self-checking bench for the 8-bit timer output compare block
`timescale 1ns/100ps

`define CMP(act, exp) \
  begin \
    checked++; \
    if ((act) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); \
    end \
  end

module test_timer8_output_compare_normal;
  import timer8_pkg::*;

  logic       clk_i;
  logic       rst_b_i;
  logic       tick_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       irq_ovf_o;
  logic       irq_cmp_a_o;
  logic       irq_cmp_b_o;
  logic       ack_ovf_i;
  logic       ack_cmp_a_i;
  logic       ack_cmp_b_i;
  logic [1:0] port_data_i;
  logic [1:0] compare_pin_direction_i;
  logic [1:0] pin_o;
  logic [1:0] pin_oe_o;
  int         n_mismatch;
  int         checked;
  logic [1:0] coma_tbl [5];
  logic       st_tbl   [5];

  timer8_output_compare_normal timer8_output_compare_normal_inst (
    .clk_i                   (clk_i),
    .rst_b_i                 (rst_b_i),
    .tick_i                  (tick_i),
    .addr_i                  (addr_i),
    .wdata_i                 (wdata_i),
    .wr_i                    (wr_i),
    .rd_i                    (rd_i),
    .rdata_o                 (rdata_o),
    .irq_ovf_o               (irq_ovf_o),
    .irq_cmp_a_o             (irq_cmp_a_o),
    .irq_cmp_b_o             (irq_cmp_b_o),
    .ack_ovf_i               (ack_ovf_i),
    .ack_cmp_a_i             (ack_cmp_a_i),
    .ack_cmp_b_i             (ack_cmp_b_i),
    .port_data_i             (port_data_i),
    .compare_pin_direction_i (compare_pin_direction_i),
    .pin_o                   (pin_o),
    .pin_oe_o                (pin_oe_o)
  );

  always #5 clk_i = ~clk_i;

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // optional tick in the write cycle to exercise write priority
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic t = 1'b0);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    tick_i  <= t;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    tick_i  <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    `CMP(rdata_o, e)
  endtask : chk

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk_i);
      tick_i <= 1'b1;
      @(posedge clk_i);
      tick_i <= 1'b0;
    end
  endtask : tk

  task automatic ack(input logic [2:0] m);
    @(posedge clk_i);
    {ack_cmp_b_i, ack_cmp_a_i, ack_ovf_i} <= m;
    @(posedge clk_i);
    {ack_cmp_b_i, ack_cmp_a_i, ack_ovf_i} <= 3'h0;
    #1;
  endtask : ack

  // watchdog: the sequence never waits on the design, so this only catches a stall
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    conclude();
  end

  initial begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    tick_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    {ack_cmp_b_i, ack_cmp_a_i, ack_ovf_i} = 3'h0;
    port_data_i = 2'b10;
    compare_pin_direction_i = 2'b10;
    n_mismatch = 0;
    checked = 0;
    coma_tbl = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0};
    st_tbl   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1;
    `CMP(pin_o, port_data_i)
    `CMP(pin_oe_o, compare_pin_direction_i)
    for (int a = 0; a < 16; a++) begin
      chk(a[3:0], 8'h00);
    end
    @(posedge clk_i);
    #1;
    `CMP(rdata_o, 8'h00)
    // forced compares across every output mode, timer stopped
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL, {2'h0, coma_tbl[i], 4'h0});
      wr(OFS_FORCE, 8'h01);
      chk(OFS_OUT_STATE, {7'h0, st_tbl[i]});
      `CMP(pin_o[0], (coma_tbl[i] != 2'h0) ? st_tbl[i] : port_data_i[0])
    end
    // preset output state, then turn the pin to output
    wr(OFS_CTRL, 8'h30);
    `CMP({pin_oe_o[0], pin_o[0]}, 2'b01)
    @(posedge clk_i);
    compare_pin_direction_i <= 2'b11;
    @(posedge clk_i);
    #1;
    `CMP({pin_oe_o, pin_o}, 4'hf)
    @(posedge clk_i);
    compare_pin_direction_i <= 2'b10;
    chk(OFS_FLAGS, 8'h00);
    chk(OFS_COUNT, 8'h00);
    wr(OFS_CTRL, 8'h03);
    chk(OFS_OUT_STATE, 8'h01);
    // buffered writes in fast pwm never reach the active value while stopped
    wr(OFS_COUNT, 8'h10);
    wr(OFS_CMP_A, 8'h40);
    chk(OFS_CMP_A, 8'h40);
    wr(OFS_CTRL, 8'h00);
    chk(OFS_CMP_A, 8'h00);
    wr(OFS_CMP_A, 8'h05);
    chk(OFS_CMP_A, 8'h05);
    // run normal mode, toggle on channel a match
    wr(OFS_CTRL, 8'h18);
    wr(OFS_CMP_B, 8'h80);
    wr(OFS_COUNT, 8'h03);
    tk(3);
    chk(OFS_FLAGS, 8'h00);
    chk(OFS_OUT_STATE, 8'h00);
    `CMP({pin_oe_o[0], pin_o[0]}, 2'b00)
    tk(1);
    chk(OFS_FLAGS, 8'h02);
    chk(OFS_COUNT, 8'h07);
    wr(OFS_IRQ_EN, 8'h02);
    `CMP({irq_cmp_b_o, irq_cmp_a_o, irq_ovf_o}, 3'b010)
    ack(3'b010);
    `CMP(irq_cmp_a_o, 1'b0)
    chk(OFS_FLAGS, 8'h00);
    wr(OFS_CMP_B, 8'h09);
    tk(4);
    chk(OFS_FLAGS, 8'h04);
    chk(OFS_OUT_STATE, 8'h00);
    wr(OFS_FLAGS, 8'h00);
    chk(OFS_FLAGS, 8'h04);
    wr(OFS_FLAGS, 8'h04);
    chk(OFS_FLAGS, 8'h00);
    // counter written equal to the compare value: that match is lost
    wr(OFS_COUNT, 8'h05);
    tk(3);
    chk(OFS_FLAGS, 8'h00);
    chk(OFS_OUT_STATE, 8'h00);
    wr(OFS_COUNT, 8'hfd, 1'b1);
    chk(OFS_COUNT, 8'hfd);
    tk(3);
    chk(OFS_COUNT, 8'h00);
    chk(OFS_FLAGS, 8'h01);
    tk(4);
    chk(OFS_FLAGS, 8'h01);
    wr(OFS_IRQ_EN, 8'h01);
    `CMP(irq_ovf_o, 1'b1)
    ack(3'b001);
    `CMP(irq_ovf_o, 1'b0)
    // clear on match: counter returns to zero at channel a value
    wr(OFS_CTRL, 8'h0a);
    wr(OFS_COUNT, 8'h03);
    tk(3);
    chk(OFS_COUNT, 8'h00);
    // phase correct: writes wait in the buffer until the top turn
    wr(OFS_CTRL, 8'h39);
    wr(OFS_CMP_A, 8'h02);
    chk(OFS_CMP_A, 8'h02);
    wr(OFS_FORCE, 8'h01);
    chk(OFS_OUT_STATE, 8'h00);
    wr(OFS_COUNT, 8'hfe);
    tk(2);
    chk(OFS_COUNT, 8'hfe);
    wr(OFS_CTRL, 8'h00);
    chk(OFS_CMP_A, 8'h02);
    conclude();
  end
endmodule : test_timer8_output_compare_normal
